/* mnx_pkg.sv */
// Purpose: shared constants and carriers for the multiply/negate/no-op unit
// Assumes: 8-bit data path, 16-bit instruction word, four-phase cycle
// Notes:   phase counter runs q1..q4 continuously from reset
package mnx_pkg;

   // ===========================================================
   // opcode patterns
   localparam logic [6:0]  MNX_OP_MUL      = 7'h01;  // 0000 001
   localparam logic [6:0]  MNX_OP_NEG      = 7'h36;  // 0110 110
   localparam logic [3:0]  MNX_OP_IDLE_TOP  = 4'hf;
   localparam logic [15:0] MNX_OP_IDLE_ZERO = 16'h0000;
   localparam logic [7:0]  MNX_IDX_LIMIT   = 8'h5f;

   // ===========================================================
   // reset values and field positions
   localparam logic [7:0]  MNX_PROD_RST    = 8'h00;
   localparam logic [7:0]  MNX_DATA_RST    = 8'h00;
   localparam logic [15:0] MNX_INSTR_RST   = 16'h0000;
   localparam logic [4:0]  MNX_FLAGS_RST   = 5'h00;
   localparam int          MNX_ACCESS_BIT  = 8;
   localparam int          MNX_PHASES      = 4;

   // ===========================================================
   // types
   typedef enum logic [1:0] {MNX_Q1, MNX_Q2, MNX_Q3, MNX_Q4} mnx_phase_e;

   typedef enum logic [1:0]
   {
      MNX_ADDR_ACCESS,
      MNX_ADDR_BANKED,
      MNX_ADDR_INDEXED
   } mnx_mode_e;

   typedef struct packed
   {
      logic n;
      logic overflow_flag;
      logic z;
      logic digit_carry_flag;
      logic c;
   } mnx_flags_s;

   typedef struct packed
   {
      mnx_mode_e  mode;
      logic [3:0] bank;
      logic [7:0] offset;
   } mnx_addr_s;

endpackage

/* mnx_negate.sv */
// Purpose: two's-complement negate of one byte with status flags
// Assumes: purely combinational, used in the process phase
// Notes:   flags follow 0 - f subtraction semantics
`timescale 1ns/1ps
module mnx_negate
   import mnx_pkg::*;
(
   // operand
   input  wire logic [7:0] operand_i,
   // result
   output logic [7:0]      result_o,
   output mnx_flags_s      flags_o
);

   logic [8:0] sum;
   logic [4:0] low_sum;

   always_comb
   begin
      sum            = {1'b0, ~operand_i} + 9'h001;
      low_sum        = {1'b0, ~operand_i[3:0]} + 5'h01;
      result_o       = sum[7:0];
      flags_o.c      = sum[8];
      flags_o.digit_carry_flag = low_sum[4];
      flags_o.n      = sum[7];
      flags_o.z      = (sum[7:0] == 8'h00);
      // only 80h negates to itself with a sign clash
      flags_o.overflow_flag = operand_i[7] & sum[7];
   end

endmodule

/* mnx_exec.sv */
// Purpose: execute multiply-by-file, negate-file and no-operation words
// Assumes: decode supplies the word at q1; memory answers reads in q2
// Notes:   all other opcodes are ignored here and leave state untouched
//
// Contract
// - multiply pattern forms unsigned working times file
// - product high byte and low byte stored
// - multiply writes only the product pair
// - multiply never changes any status flag
// - access bit zero access bank, one banked
// - indexed mode: access zero, extended, f<=5Fh
// - negate pattern forms inverse plus one
// - negate writes back and updates five flags
`timescale 1ns/1ps
module mnx_exec
   import mnx_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        rst_n_i,
   // instruction and core state
   input  wire logic [15:0] instr_i,
   input  wire logic [7:0]  working_i,
   input  wire logic [3:0]  bank_select_register_i,
   input  wire logic        extended_set_i,
   input  wire mnx_flags_s  flags_i,
   // data memory read
   output mnx_addr_s        mem_addr_o,
   output logic             mem_rd_o,
   input  wire logic [7:0]  mem_rdata_i,
   // data memory write
   output logic             mem_wr_o,
   output logic [7:0]       mem_wdata_o,
   // results
   output logic [7:0]       product_high_o,
   output logic [7:0]       product_low_o,
   output logic             product_wr_o,
   output mnx_flags_s       flags_o,
   output logic             flags_wr_o,
   output mnx_phase_e       phase_o,
   output logic             no_operation_o
);

   // ===========================================================
   // phase sequencer
   // free-running: no stall input, so every word costs four edges
   mnx_phase_e phase_reg;
   mnx_phase_e phase_next;

   always_comb
   begin
      unique case (phase_reg)
         MNX_Q1: phase_next = MNX_Q2;
         MNX_Q2: phase_next = MNX_Q3;
         MNX_Q3: phase_next = MNX_Q4;
         MNX_Q4: phase_next = MNX_Q1;
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         phase_reg <= MNX_Q1;
      else
         phase_reg <= phase_next;
   end

   assign phase_o = phase_reg;

   // ===========================================================
   // decode, latched at q1
   // word is held through q4 so the strobes see a stable decode
   logic [15:0] instr_reg;
   logic [15:0] instr_next;
   logic        is_mul;
   logic        is_neg;
   logic        is_idle;

   always_comb
   begin
      instr_next = instr_reg;
      if (phase_reg == MNX_Q1)
         instr_next = instr_i;
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         instr_reg <= MNX_INSTR_RST;
      else
         instr_reg <= instr_next;
   end

   assign is_mul = (instr_reg[15:9] == MNX_OP_MUL);
   assign is_neg = (instr_reg[15:9] == MNX_OP_NEG);
   // no-op words fall outside both patterns, so nothing fires
   assign is_idle = (instr_reg == MNX_OP_IDLE_ZERO)
                  | (instr_reg[15:12] == MNX_OP_IDLE_TOP);
   assign no_operation_o = is_idle;

   // ===========================================================
   // operand addressing
   // mode is only a tag; bank and offset arithmetic live outside
   logic access_a;

   assign access_a = instr_reg[MNX_ACCESS_BIT];

   always_comb
   begin
      mem_addr_o.offset = instr_reg[7:0];
      mem_addr_o.bank   = bank_select_register_i;
      if (access_a)
         mem_addr_o.mode = MNX_ADDR_BANKED;
      else if (extended_set_i && instr_reg[7:0] <= MNX_IDX_LIMIT)
         mem_addr_o.mode = MNX_ADDR_INDEXED;
      else
         mem_addr_o.mode = MNX_ADDR_ACCESS;
   end

   assign mem_rd_o = (phase_reg == MNX_Q2) & (is_mul | is_neg);

   // ===========================================================
   // operand capture in q2, processing in q3
   logic [7:0]  operand_reg;
   logic [7:0]  operand_next;
   logic [15:0] product;
   logic [7:0]  neg_result;
   mnx_flags_s  neg_flags;

   always_comb
   begin
      operand_next = operand_reg;
      // latch only on a real read, so no-ops leave it alone
      if (mem_rd_o)
         operand_next = mem_rdata_i;
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         operand_reg <= MNX_DATA_RST;
      else
         operand_reg <= operand_next;
   end

   // working is sampled in q3; a later change to it is not seen
   assign product = 16'(working_i) * 16'(operand_reg);

   // negate runs every cycle; its result is kept only for negate
   mnx_negate u_negate
   (
      .operand_i (operand_reg),
      .result_o  (neg_result),
      .flags_o   (neg_flags)
   );

   // ===========================================================
   // result registers, captured in q3 and written in q4
   // products stand until the next multiply: readable core state
   logic [7:0] prod_hi_reg;
   logic [7:0] prod_hi_next;
   logic [7:0] prod_lo_reg;
   logic [7:0] prod_lo_next;
   logic [7:0] wdata_reg;
   logic [7:0] wdata_next;
   mnx_flags_s flags_reg;
   mnx_flags_s flags_next;

   always_comb
   begin
      prod_hi_next = prod_hi_reg;
      prod_lo_next = prod_lo_reg;
      wdata_next   = wdata_reg;
      flags_next   = flags_reg;
      if (phase_reg == MNX_Q3)
      begin
         // working register and file are never driven here
         if (is_mul)
         begin
            prod_hi_next = product[15:8];
            prod_lo_next = product[7:0];
         end
         if (is_neg)
         begin
            wdata_next = neg_result;
            flags_next = neg_flags;
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         prod_hi_reg <= MNX_PROD_RST;
         prod_lo_reg <= MNX_PROD_RST;
         wdata_reg   <= MNX_DATA_RST;
         flags_reg   <= MNX_FLAGS_RST;
      end
      else
      begin
         prod_hi_reg <= prod_hi_next;
         prod_lo_reg <= prod_lo_next;
         wdata_reg   <= wdata_next;
         flags_reg   <= flags_next;
      end
   end

   // ===========================================================
   // write-back strobes in q4
   // strobes are decoded, not registered, so they land inside q4
   assign product_high_o = prod_hi_reg;
   assign product_low_o  = prod_lo_reg;
   assign product_wr_o   = (phase_reg == MNX_Q4) & is_mul;
   assign mem_wdata_o    = wdata_reg;
   assign mem_wr_o       = (phase_reg == MNX_Q4) & is_neg;
   // flags pass through untouched unless negate writes them
   assign flags_wr_o     = (phase_reg == MNX_Q4) & is_neg;
   assign flags_o        = flags_wr_o ? flags_reg : flags_i;

endmodule

/* mnx_exec_assertions.sv */
// Purpose: port checks of mnx_exec
// Assumes: one clock, async low reset
// Notes:   bound below
`timescale 1ns/1ps
module mnx_exec_assertions
   import mnx_pkg::*;
(
   // inputs
   input wire logic        sys_clk_i,
   input wire logic        rst_n_i,
   input wire logic [15:0] instr_i,
   input wire logic [7:0]  working_i,
   input wire logic        extended_set_i,
   input wire mnx_flags_s  flags_i,
   input wire logic [7:0]  mem_rdata_i,
   // outputs
   input wire mnx_addr_s   mem_addr_o,
   input wire logic        mem_rd_o,
   input wire logic        mem_wr_o,
   input wire logic [7:0]  mem_wdata_o,
   input wire logic [7:0]  product_high_o,
   input wire logic [7:0]  product_low_o,
   input wire logic        product_wr_o,
   input wire mnx_flags_s  flags_o,
   input wire logic        flags_wr_o,
   input wire mnx_phase_e  phase_o
);
   // ======================
   // checks
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   a_read_phase: assert property (
      mem_rd_o |-> phase_o == MNX_Q2) else $error("read off q2");
   a_mul_strobe: assert property (
      phase_o == MNX_Q1 && instr_i[15:9] == MNX_OP_MUL |->
      ##3 product_wr_o && !mem_wr_o) else $error("mul strobe");
   a_neg_strobe: assert property (
      phase_o == MNX_Q1 && instr_i[15:9] == MNX_OP_NEG |->
      ##3 mem_wr_o && flags_wr_o) else $error("neg strobe");
   a_idle_quiet: assert property (
      phase_o == MNX_Q1 && (instr_i[15:12] == MNX_OP_IDLE_TOP ||
      instr_i == MNX_OP_IDLE_ZERO) |->
      ##1 (!mem_rd_o && !mem_wr_o && !product_wr_o)[*3])
      else $error("idle word active");
   a_mul_value: assert property (
      product_wr_o |-> {product_high_o, product_low_o} ==
      16'($past(working_i)) * 16'($past(mem_rdata_i, 2)))
      else $error("product value");
   a_neg_value: assert property (
      mem_wr_o |-> mem_wdata_o == 8'(~$past(mem_rdata_i, 2) + 8'h01))
      else $error("neg value");
   a_flag_echo: assert property (
      !flags_wr_o |-> flags_o == flags_i) else $error("flags moved");
   a_neg_zero: assert property (
      flags_wr_o |-> flags_o.z == (mem_wdata_o == 8'h00))
      else $error("zero flag");
   a_addr_mode: assert property (
      mem_rd_o |-> mem_addr_o.mode == ($past(instr_i[8]) ?
      MNX_ADDR_BANKED : extended_set_i && $past(instr_i[7:0]) <=
      MNX_IDX_LIMIT ? MNX_ADDR_INDEXED : MNX_ADDR_ACCESS))
      else $error("address mode");
endmodule
bind mnx_exec mnx_exec_assertions mnx_exec_assertions_inst (.*);

/* mnx_mem_model.sv */
// Purpose: data memory beside mnx_exec
// Assumes: read answered within q2
// Notes:   offset only, bank ignored
`timescale 1ns/1ps
module mnx_mem_model
   import mnx_pkg::*;
(
   // memory side
   input  wire logic       sys_clk_i,
   input  wire mnx_addr_s  mem_addr_i,
   input  wire logic       mem_rd_i,
   input  wire logic       mem_wr_i,
   input  wire logic [7:0] mem_wdata_i,
   output logic [7:0]      mem_rdata_o
);
   logic [7:0] mem [256];
   // idle bus inverted, so no stale match
   assign mem_rdata_o = mem_rd_i ? mem[mem_addr_i.offset]
                                 : ~mem[mem_addr_i.offset];
   always @(posedge sys_clk_i)
      if (mem_wr_i)
         mem[mem_addr_i.offset] <= mem_wdata_i;
endmodule

/* test_mnx_exec.sv */
// Purpose: directed bench of mnx_exec
// Assumes: memory model on the far side
// Notes:   each word waits for q1
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
   $display("BAD %0t got %h exp %h", $time, g, e); end end
module test_mnx_exec
   import mnx_pkg::*;
   ;
   logic        sys_clk_i = 1'b0, rst_n_i = 1'b0, extended_set_i = 1'b0;
   logic [15:0] instr_i = 16'h0000;
   logic [7:0]  working_i = 8'h00;
   logic [3:0]  bank_select_register_i = 4'h3;
   mnx_flags_s  flags_i = 5'h0a;
   logic [7:0]  mem_rdata_i, mem_wdata_o, product_high_o, product_low_o;
   mnx_addr_s   mem_addr_o;
   mnx_flags_s  flags_o;
   mnx_phase_e  phase_o;
   logic        mem_rd_o, mem_wr_o, product_wr_o, flags_wr_o;
   logic        no_operation_o;
   int          n_mismatch = 0, n_tests = 0, cyc = 0;

   mnx_exec mnx_exec_inst (.*);
   mnx_mem_model mnx_mem_model_inst (.sys_clk_i(sys_clk_i),
      .mem_addr_i(mem_addr_o), .mem_rd_i(mem_rd_o), .mem_wr_i(mem_wr_o),
      .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i));

   initial forever #5 sys_clk_i = ~sys_clk_i;
   always @(posedge sys_clk_i)
      if (++cyc == 1000)
      begin
         n_mismatch++;
         end_sim();
      end

   task automatic end_sim();
      $display("compares %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // ======================
   // one word q1..q4, strobes judged in q4
   task automatic run(logic [15:0] w, logic [7:0] wr, logic [2:0] s);
      do
      begin
         @(posedge sys_clk_i);
         #1;
      end while (phase_o !== MNX_Q1);
      instr_i = w;
      working_i = wr;
      repeat (3) @(posedge sys_clk_i);
      #1;
      `CHK({product_wr_o, mem_wr_o, flags_wr_o}, s)
      instr_i = 16'h0000;
   endtask

   task automatic t_mul();
      mnx_mem_model_inst.mem[8'h35] = 8'hb5;
      run(16'h0335, 8'hc4, 3'b100);
      `CHK({product_high_o, product_low_o}, 16'h8a94)
      `CHK(mem_addr_o, {MNX_ADDR_BANKED, 4'h3, 8'h35})
      `CHK(mnx_mem_model_inst.mem[8'h35], 8'hb5)
      extended_set_i = 1'b1;
      mnx_mem_model_inst.mem[8'h5f] = 8'hff;
      run(16'h025f, 8'hff, 3'b100);
      `CHK({product_high_o, product_low_o}, 16'hfe01)
      `CHK(mem_addr_o.mode, MNX_ADDR_INDEXED)
      mnx_mem_model_inst.mem[8'h60] = 8'h00;
      run(16'h0260, 8'h12, 3'b100);
      `CHK({product_low_o, flags_o}, {8'h00, flags_i})
      `CHK(mem_addr_o.mode, MNX_ADDR_ACCESS)
      $display("mul done");
   endtask

   task automatic t_neg();
      logic [7:0] v [3] = '{8'h3a, 8'h00, 8'h80};
      logic [7:0] r [3] = '{8'hc6, 8'h00, 8'h80};
      logic [4:0] f [3] = '{5'h10, 5'h07, 5'h1a};
      for (int i = 0; i < 3; i++)
      begin
         mnx_mem_model_inst.mem[8'h41] = v[i];
         run(i == 2 ? 16'h6c41 : 16'h6d41, 8'h00, 3'b011);
         `CHK(flags_o, f[i])
         @(posedge sys_clk_i);
         #1;
         `CHK(mnx_mem_model_inst.mem[8'h41], r[i])
      end
      $display("neg done");
   endtask

   task automatic t_idle();
      run(16'h0335, 8'hc4, 3'b100);
      run(16'h0000, 8'h77, 3'b000);
      `CHK(no_operation_o, 1'b1)
      run(16'hf123, 8'h77, 3'b000);
      `CHK({no_operation_o, flags_o}, {1'b1, flags_i})
      `CHK({product_high_o, product_low_o}, 16'h8a94)
      $display("idle done");
   endtask

   initial
   begin
      repeat (8) @(posedge sys_clk_i);
      #1;
      rst_n_i = 1'b1;
      t_mul();
      t_neg();
      t_idle();
      end_sim();
   end
endmodule
